/* File: src/psm_pkg.sv */
// shared constants and types for the power-save mode controller
package psm_pkg;
	// register bus shape
	localparam int PSM_ADDR_W = 4;
	localparam int PSM_DATA_W = 32;
	// register byte offsets
	localparam logic [3:0] PSM_OFS_DIVISOR = 4'h0;
	localparam logic [3:0] PSM_OFS_OSCCTL  = 4'h4;
	localparam logic [3:0] PSM_OFS_STATUS  = 4'h8;
	// clock divisor register fields
	localparam int PSM_RECOV_BIT = 15;
	localparam int PSM_RATIO_LSB = 12;
	localparam int PSM_RATIO_W   = 3;
	localparam int PSM_CPU_SLOWDOWN_ENABLE_BIT = 11;
	// oscillator control register fields
	localparam int PSM_OSC_W    = 3;
	localparam int PSM_COSC_LSB = 12;
	localparam int PSM_NEXT_LSB = 8;
	// status register fields
	localparam int PSM_ST_STATE_LSB = 0;
	localparam int PSM_ST_HELD_BIT  = 8;
	localparam int PSM_ST_DOZE_BIT  = 9;
	localparam int PSM_ST_ISR_BIT   = 10;
	// values after reset
	localparam logic                   PSM_RECOV_RST = 1'b0;
	localparam logic [PSM_RATIO_W-1:0] PSM_RATIO_RST = 3'h0;
	localparam logic                   PSM_CPU_SLOWDOWN_ENABLE_RST = 1'b0;
	localparam logic [PSM_OSC_W-1:0]   PSM_NEXT_RST  = 3'h0;
	// doze divider counter, wide enough for a 1:128 ratio
	localparam int PSM_DOZE_CNT_W = 7;
	// power-state sequencer
	typedef enum logic [4:0] {
		PSM_RUN   = 5'h01,
		PSM_ENTER = 5'h02,
		PSM_SLEEP = 5'h04,
		PSM_IDLE  = 5'h08,
		PSM_WAKE  = 5'h10
	} psm_state_t;
endpackage

/* File: src/psm_sync2.sv */
// two-flop synchroniser for levels arriving from another clock domain
`timescale 1ns/10ps
module psm_sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	// first stage feeds only the second stage
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end
	end

	assign sync_out = sync_reg;
endmodule

/* File: src/psm_doze_div.sv */
// doze divider: one cpu enable cycle out of every 2**ratio system cycles
`timescale 1ns/10ps
module psm_doze_div #(
	parameter int RATIO_W = psm_pkg::PSM_RATIO_W,
	parameter int CNT_W   = psm_pkg::PSM_DOZE_CNT_W
) (
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               doze_en,
	input  wire logic [RATIO_W-1:0] ratio,
	output logic                    tick
);
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] limit;

	// limit is N-1; a ratio lowered mid-count wraps at once via >=
	assign limit = CNT_W'((1 << ratio) - 1);

	// counter stays edge aligned with the system clock, no derived clock
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_reg <= '0;
		end else if (!doze_en || cnt_reg >= limit) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end

	assign tick = !doze_en || (cnt_reg == '0); // see (RULE23)
endmodule

/* File: src/psm_power_ctrl.sv */
// power-save mode controller: sleep, idle and doze sequencing with an avalon-mm register slave
//
// Implementation choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/10ps
// Operation
// (RULE1) sleep or idle is entered only by the power-save instruction; operand picks which
// (RULE2) sleep stops all clocks and halts instruction execution
// (RULE3) idle halts the cpu but peripherals keep running
// (RULE4) enabled interrupt, any reset or watchdog time-out wakes from sleep or idle
// (RULE5) sleep shuts the system clock source and an on-chip oscillator in use
// (RULE6) clock-failure monitor is inactive during sleep
// (RULE7) low-power rc clock keeps running in sleep when watchdog is enabled
// (RULE8) watchdog counter is cleared just before sleep when watchdog is enabled
// (RULE9) peripherals needing the system clock are disabled during sleep
// (RULE10) wake from sleep resumes on the clock source selected at entry
// (RULE11) watchdog counter is cleared on idle entry
// (RULE12) system clock stays active in idle and peripherals run from it
// (RULE13) rc clock stays running in idle if watchdog or failure monitor enabled
// (RULE14) idle wake restores the cpu clock; resume after instruction or in the isr
// (RULE15) interrupt coincident with the instruction is held until entry, then wakes
// (RULE16) next oscillator select, bits 10:8, is writable while clock config unlocked
// (RULE17) doze slows only the cpu clock; system clock and peripherals unchanged
// (RULE18) doze is active while slowdown enable, clock divisor bit 11, is set
// (RULE19) ratio field bits 14:12 gives 1:1 to 1:128, default 1:1
// (RULE20) recover-on-interrupt bit 15 set: an interrupt returns the cpu to full speed
// (RULE21) recover-on-interrupt clear: interrupts leave doze unchanged
// (RULE22) hardware clears slowdown enable on an interrupt while recover-on-interrupt set
// (RULE23) doze cpu clock is one enable cycle every n system cycles
module psm_power_ctrl #(
	parameter logic [7:0] ONCHIP_SRC_MASK = 8'hff
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        power_save_instruction_exec,
	input  wire logic        power_save_instruction_idle,
	input  wire logic        irq_pending,
	input  wire logic        wdt_timeout_async,
	input  wire logic        watchdog_enable,
	input  wire logic        clock_failure_monitor_enable,
	input  wire logic        clock_config_locked,
	output logic             cpu_clk_en,
	output logic             periph_clk_en,
	output logic             sysclk_src_en,
	output logic             onchip_osc_en,
	output logic             low_power_rc_clock_en,
	output logic             clock_failure_monitor_active,
	output logic             watchdog_counter_clear,
	output logic             cpu_resume,
	output logic             resume_to_isr,
	output logic             doze_active,
	output logic [2:0]       current_oscillator
);
	psm_pkg::psm_state_t state_reg;
	psm_pkg::psm_state_t state_next;

	logic       mode_idle_reg;
	logic       held_irq_reg;
	logic       isr_wake_reg;
	logic       wdt_timeout_s;
	logic       wake_evt;
	logic       doze_tick;
	logic       recov_reg;
	logic [2:0] ratio_reg;
	logic       cpu_slowdown_enable_reg;
	logic [2:0] next_osc_reg;
	logic [2:0] cosc_reg;
	logic [2:0] saved_osc_reg;
	logic       sleep_next;
	logic       run_next;

	logic [31:0] avs_readdata_reg;
	logic [31:0] rd_data;
	logic        avs_waitrequest_reg;
	logic        wr_fire;
	logic        wr_divisor;
	logic        wr_oscctl;

	logic cpu_clk_en_reg;
	logic periph_clk_en_reg;
	logic sysclk_src_en_reg;
	logic onchip_osc_en_reg;
	logic rc_clk_en_reg;
	logic monitor_active_reg;
	logic wdt_clear_reg;
	logic cpu_resume_reg;
	logic doze_active_reg;

	// watchdog time-out comes from the rc clock domain
	psm_sync2 #(
		.WIDTH(1)
	) u_wdt_sync (
		.clk      (clk),
		.rst_n    (rst_n),
		.async_in (wdt_timeout_async),
		.sync_out (wdt_timeout_s)
	);

	// cpu enable pacing while doze is on
	psm_doze_div #(
		.RATIO_W(psm_pkg::PSM_RATIO_W),
		.CNT_W  (psm_pkg::PSM_DOZE_CNT_W)
	) u_doze_div (
		.clk     (clk),
		.rst_n   (rst_n),
		.doze_en (cpu_slowdown_enable_reg),
		.ratio   (ratio_reg),
		.tick    (doze_tick)
	);

	// bus handshake: one wait cycle, the access completes on the edge that sees waitrequest low
	assign wr_fire   = avs_write && !avs_waitrequest_reg;
	assign wr_divisor = wr_fire && (avs_address == psm_pkg::PSM_OFS_DIVISOR) && avs_byteenable[1];
	assign wr_oscctl = wr_fire && (avs_address == psm_pkg::PSM_OFS_OSCCTL) && avs_byteenable[1];

	// wake sources: interrupt, watchdog time-out, or an interrupt held across entry
	assign wake_evt = irq_pending || wdt_timeout_s || held_irq_reg; // see (RULE4)

	// next power state
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			psm_pkg::PSM_RUN: begin
				if (power_save_instruction_exec) begin
					state_next = psm_pkg::PSM_ENTER; // see (RULE1)
				end
			end
			psm_pkg::PSM_ENTER: begin
				state_next = mode_idle_reg ? psm_pkg::PSM_IDLE : psm_pkg::PSM_SLEEP;
			end
			psm_pkg::PSM_SLEEP, psm_pkg::PSM_IDLE: begin
				if (wake_evt) begin
					state_next = psm_pkg::PSM_WAKE;
				end
			end
			psm_pkg::PSM_WAKE: begin
				state_next = psm_pkg::PSM_RUN; // see (RULE14)
			end
		endcase
	end

	// device reset always lands in run, which is also a wake
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= psm_pkg::PSM_RUN; // see (RULE4)
		end else begin
			state_reg <= state_next;
		end
	end

	// operand is caught with the instruction
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode_idle_reg <= 1'b0;
		end else if (state_reg == psm_pkg::PSM_RUN && power_save_instruction_exec) begin
			mode_idle_reg <= power_save_instruction_idle; // see (RULE1)
		end
	end

	// an interrupt during entry is parked here, so entry always finishes first
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			held_irq_reg <= 1'b0;
		end else if ((state_reg == psm_pkg::PSM_RUN && power_save_instruction_exec && irq_pending)
			|| (state_reg == psm_pkg::PSM_ENTER && irq_pending)) begin
			held_irq_reg <= 1'b1; // see (RULE15)
		end else if (state_reg == psm_pkg::PSM_WAKE) begin
			held_irq_reg <= 1'b0;
		end
	end

	// tells the cpu whether to vector to the isr or fall through
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			isr_wake_reg <= 1'b0;
		end else if ((state_reg == psm_pkg::PSM_SLEEP || state_reg == psm_pkg::PSM_IDLE) && wake_evt) begin
			isr_wake_reg <= irq_pending || held_irq_reg; // see (RULE14)
		end
	end

	// clock divisor register; hardware recovery beats a same-cycle software set
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			recov_reg <= psm_pkg::PSM_RECOV_RST;
			ratio_reg <= psm_pkg::PSM_RATIO_RST; // see (RULE19)
			cpu_slowdown_enable_reg <= psm_pkg::PSM_CPU_SLOWDOWN_ENABLE_RST;
		end else begin
			if (wr_divisor) begin
				recov_reg <= avs_writedata[psm_pkg::PSM_RECOV_BIT]; // see (RULE20)
				ratio_reg <= avs_writedata[psm_pkg::PSM_RATIO_LSB +: psm_pkg::PSM_RATIO_W];
				cpu_slowdown_enable_reg <= avs_writedata[psm_pkg::PSM_CPU_SLOWDOWN_ENABLE_BIT]; // see (RULE18)
			end
			if (irq_pending && recov_reg) begin
				cpu_slowdown_enable_reg <= 1'b0; // see (RULE22)
			end
		end
	end

	// next oscillator select is frozen while the clock configuration is locked
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			next_osc_reg <= psm_pkg::PSM_NEXT_RST;
		end else if (wr_oscctl && !clock_config_locked) begin
			next_osc_reg <= avs_writedata[psm_pkg::PSM_NEXT_LSB +: psm_pkg::PSM_OSC_W]; // see (RULE16)
		end
	end

	// source in use; switch is immediate here, the start-up sequencing lives elsewhere
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cosc_reg      <= psm_pkg::PSM_NEXT_RST;
			saved_osc_reg <= psm_pkg::PSM_NEXT_RST;
		end else begin
			if (state_reg == psm_pkg::PSM_ENTER) begin
				saved_osc_reg <= cosc_reg;
			end
			if (state_reg == psm_pkg::PSM_WAKE) begin
				cosc_reg <= saved_osc_reg; // see (RULE10)
			end else if (state_reg == psm_pkg::PSM_RUN && !clock_config_locked) begin
				cosc_reg <= next_osc_reg;
			end
		end
	end

	assign sleep_next = (state_next == psm_pkg::PSM_SLEEP);
	assign run_next   = (state_next == psm_pkg::PSM_RUN);

	// clock gating outputs follow the next state so they change with it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cpu_clk_en_reg    <= 1'b1;
			periph_clk_en_reg <= 1'b1;
			sysclk_src_en_reg <= 1'b1;
			onchip_osc_en_reg <= 1'b1;
		end else begin
			cpu_clk_en_reg    <= run_next && doze_tick; // see (RULE2) (RULE3) (RULE17) (RULE23)
			periph_clk_en_reg <= !sleep_next; // see (RULE9) (RULE12) (RULE17)
			sysclk_src_en_reg <= !sleep_next; // see (RULE5) (RULE12)
			onchip_osc_en_reg <= !(sleep_next && ONCHIP_SRC_MASK[cosc_reg]); // see (RULE5)
		end
	end

	// rc clock and failure monitor; monitor is useless once the source is off
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rc_clk_en_reg      <= 1'b0;
			monitor_active_reg <= 1'b0;
		end else begin
			rc_clk_en_reg      <= watchdog_enable || (clock_failure_monitor_enable && !sleep_next); // see (RULE7) (RULE13)
			monitor_active_reg <= clock_failure_monitor_enable && !sleep_next; // see (RULE6)
		end
	end

	// one-cycle pulses: watchdog clear on idle entry or on sleep entry with watchdog enabled, resume on wake
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wdt_clear_reg  <= 1'b0;
			cpu_resume_reg <= 1'b0;
		end else begin
			wdt_clear_reg  <= (state_reg == psm_pkg::PSM_ENTER) && (mode_idle_reg || watchdog_enable); // see (RULE8) (RULE11)
			cpu_resume_reg <= (state_reg == psm_pkg::PSM_WAKE); // see (RULE14)
		end
	end

	// doze reported only while slowdown is enabled and the cpu is in run, even at ratio 1:1
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			doze_active_reg <= 1'b0;
		end else begin
			doze_active_reg <= cpu_slowdown_enable_reg && run_next; // see (RULE18) (RULE21)
		end
	end

	// read mux; unmapped offsets read zero and ignore writes
	always_comb begin
		rd_data = '0;
		unique case (avs_address)
			psm_pkg::PSM_OFS_DIVISOR: begin
				rd_data[psm_pkg::PSM_RECOV_BIT]                            = recov_reg;
				rd_data[psm_pkg::PSM_RATIO_LSB +: psm_pkg::PSM_RATIO_W]    = ratio_reg;
				rd_data[psm_pkg::PSM_CPU_SLOWDOWN_ENABLE_BIT]                            = cpu_slowdown_enable_reg;
			end
			psm_pkg::PSM_OFS_OSCCTL: begin
				rd_data[psm_pkg::PSM_COSC_LSB +: psm_pkg::PSM_OSC_W] = cosc_reg;
				rd_data[psm_pkg::PSM_NEXT_LSB +: psm_pkg::PSM_OSC_W] = next_osc_reg;
			end
			psm_pkg::PSM_OFS_STATUS: begin
				rd_data[psm_pkg::PSM_ST_STATE_LSB +: 5] = state_reg;
				rd_data[psm_pkg::PSM_ST_HELD_BIT]       = held_irq_reg;
				rd_data[psm_pkg::PSM_ST_DOZE_BIT]       = doze_active_reg;
				rd_data[psm_pkg::PSM_ST_ISR_BIT]        = isr_wake_reg;
			end
			default: begin
				rd_data = '0;
			end
		endcase
	end

	// waitrequest drops for exactly one cycle per request
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			avs_waitrequest_reg <= 1'b1;
			avs_readdata_reg    <= '0;
		end else if (!avs_waitrequest_reg) begin
			avs_waitrequest_reg <= 1'b1;
		end else if (avs_read || avs_write) begin
			avs_waitrequest_reg <= 1'b0;
			avs_readdata_reg    <= rd_data;
		end
	end

	assign avs_readdata                 = avs_readdata_reg;
	assign avs_waitrequest              = avs_waitrequest_reg;
	assign cpu_clk_en                   = cpu_clk_en_reg;
	assign periph_clk_en                = periph_clk_en_reg;
	assign sysclk_src_en                = sysclk_src_en_reg;
	assign onchip_osc_en                = onchip_osc_en_reg;
	assign low_power_rc_clock_en        = rc_clk_en_reg;
	assign clock_failure_monitor_active = monitor_active_reg;
	assign watchdog_counter_clear       = wdt_clear_reg;
	assign cpu_resume                   = cpu_resume_reg;
	assign resume_to_isr                = isr_wake_reg;
	assign doze_active                  = doze_active_reg;
	assign current_oscillator           = cosc_reg;

	// checks on the sequencer, the clock gates and the divisor register
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_entry_needs_instr: assert property ( // see (RULE1)
		(state_reg == psm_pkg::PSM_RUN && !power_save_instruction_exec) |=> state_reg != psm_pkg::PSM_ENTER)
		else $error("power-save entry without the instruction");
	a_sleep_all_off: assert property ( // see (RULE2)
		(state_reg == psm_pkg::PSM_SLEEP) |-> !cpu_clk_en_reg && !periph_clk_en_reg && !sysclk_src_en_reg)
		else $error("a clock still runs in sleep");
	a_idle_periph_run: assert property ( // see (RULE3)
		(state_reg == psm_pkg::PSM_IDLE) |-> !cpu_clk_en_reg && periph_clk_en_reg && sysclk_src_en_reg)
		else $error("idle clock gating wrong");
	a_wdt_wakes_fast: assert property ( // see (RULE4)
		((state_reg == psm_pkg::PSM_SLEEP || state_reg == psm_pkg::PSM_IDLE) && wdt_timeout_s)
		|=> state_reg == psm_pkg::PSM_WAKE ##1 (state_reg == psm_pkg::PSM_RUN && cpu_resume_reg))
		else $error("watchdog time-out did not wake");
	a_monitor_off_sleep: assert property ( // see (RULE6)
		(state_reg == psm_pkg::PSM_SLEEP) |-> !monitor_active_reg)
		else $error("failure monitor active in sleep");
	a_rc_runs_sleep: assert property ( // see (RULE7)
		(state_reg == psm_pkg::PSM_SLEEP && $past(watchdog_enable)) |-> rc_clk_en_reg)
		else $error("rc clock stopped with watchdog enabled");
	a_wdt_clear_sleep: assert property ( // see (RULE8)
		(state_reg == psm_pkg::PSM_ENTER && watchdog_enable) |=> wdt_clear_reg && !$past(wdt_clear_reg))
		else $error("watchdog not cleared on entry");
	a_idle_wdt_clear: assert property ( // see (RULE11)
		(state_reg == psm_pkg::PSM_ENTER && mode_idle_reg) |=> wdt_clear_reg ##1 (state_reg == psm_pkg::PSM_IDLE
		|| state_reg == psm_pkg::PSM_WAKE))
		else $error("idle entry did not clear the watchdog");
	a_osc_kept_sleep: assert property ( // see (RULE10)
		(state_reg == psm_pkg::PSM_SLEEP) |-> cosc_reg == saved_osc_reg && $stable(cosc_reg))
		else $error("clock source moved during sleep");
	a_held_irq_wakes: assert property ( // see (RULE15)
		(state_reg == psm_pkg::PSM_ENTER && irq_pending)
		|=> (state_reg == psm_pkg::PSM_SLEEP || state_reg == psm_pkg::PSM_IDLE) ##1 state_reg == psm_pkg::PSM_WAKE)
		else $error("coincident interrupt did not wake after entry");
	a_osc_sel_locked: assert property ( // see (RULE16)
		(wr_oscctl && clock_config_locked) |=> $stable(next_osc_reg))
		else $error("oscillator select changed while locked");
	a_irq_ends_doze: assert property ( // see (RULE20)
		(irq_pending && recov_reg) |=> !cpu_slowdown_enable_reg ##1 !doze_active_reg)
		else $error("interrupt did not end doze");
	a_irq_keeps_doze: assert property ( // see (RULE21)
		(irq_pending && !recov_reg && cpu_slowdown_enable_reg && !wr_divisor) |=> cpu_slowdown_enable_reg)
		else $error("interrupt changed doze without recovery");

	c_sleep_wake: cover property (state_reg == psm_pkg::PSM_SLEEP ##1 state_reg == psm_pkg::PSM_WAKE);
	c_idle_wake: cover property (state_reg == psm_pkg::PSM_IDLE ##1 state_reg == psm_pkg::PSM_WAKE);
	c_held_irq: cover property (state_reg == psm_pkg::PSM_ENTER && irq_pending);
	c_doze_slow: cover property (doze_active_reg && ratio_reg == 3'h7 && !cpu_clk_en_reg);
endmodule

/* File: bench/tb_top.sv */
// self-checking testbench for the power-save mode controller
`timescale 1ns/10ps
module tb_top;
	typedef struct {
		logic idle;
		logic wd;
		logic fm;
		logic by_wdt;
		logic periph;
		logic rc;
		logic fma;
		logic clr;
		logic isr;
	} psm_row_t;

	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        exec = 1'b0;
	logic        idle_sel = 1'b0;
	logic        irq_pending = 1'b0;
	logic        wdt_timeout_async = 1'b0;
	logic        watchdog_enable = 1'b0;
	logic        fm_enable = 1'b0;
	logic        locked = 1'b0;
	logic        cpu_clk_en;
	logic        periph_clk_en;
	logic        sysclk_src_en;
	logic        onchip_osc_en;
	logic        rc_en;
	logic        fm_active;
	logic        wd_clear;
	logic        cpu_resume;
	logic        resume_to_isr;
	logic        doze_active;
	logic [2:0]  current_oscillator;
	int          errors = 0;
	int          total_checks = 0;
	int          clr_cnt = 0;
	int          res_cnt = 0;
	logic [31:0] d;
	int          hi;
	int          plo;
	int          c0;
	int          r0;
	int          n;
	// sleep and idle cases: operand, enables, wake source, then the outputs they should give
	psm_row_t    rows [5] = '{
		'{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1},
		'{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1},
		'{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1},
		'{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0},
		'{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0}
	};

	psm_power_ctrl dut (
		.clk                          (clk),
		.rst_n                        (rst_n),
		.avs_address                  (avs_address),
		.avs_read                     (avs_read),
		.avs_write                    (avs_write),
		.avs_writedata                (avs_writedata),
		.avs_byteenable               (avs_byteenable),
		.avs_readdata                 (avs_readdata),
		.avs_waitrequest              (avs_waitrequest),
		.power_save_instruction_exec  (exec),
		.power_save_instruction_idle  (idle_sel),
		.irq_pending                  (irq_pending),
		.wdt_timeout_async            (wdt_timeout_async),
		.watchdog_enable              (watchdog_enable),
		.clock_failure_monitor_enable (fm_enable),
		.clock_config_locked          (locked),
		.cpu_clk_en                   (cpu_clk_en),
		.periph_clk_en                (periph_clk_en),
		.sysclk_src_en                (sysclk_src_en),
		.onchip_osc_en                (onchip_osc_en),
		.low_power_rc_clock_en        (rc_en),
		.clock_failure_monitor_active (fm_active),
		.watchdog_counter_clear       (wd_clear),
		.cpu_resume                   (cpu_resume),
		.resume_to_isr                (resume_to_isr),
		.doze_active                  (doze_active),
		.current_oscillator           (current_oscillator)
	);

	always #5 clk = ~clk;

	// one-cycle pulses are counted here so no test can miss them
	always @(posedge clk) begin
		if (wd_clear === 1'b1) clr_cnt <= clr_cnt + 1;
		if (cpu_resume === 1'b1) res_cnt <= res_cnt + 1;
	end

	task automatic chk1(input logic a, input logic e, input string m);
		total_checks++;
		if (a !== e) begin
			errors++;
			$display("MISMATCH at %0t: %s got %b want %b", $time, m, a, e);
		end
	endtask

	task automatic chk32(input logic [31:0] a, input logic [31:0] e, input string m);
		total_checks++;
		if (a !== e) begin
			errors++;
			$display("MISMATCH at %0t: %s got %h want %h", $time, m, a, e);
		end
	endtask

	// request held until waitrequest is sampled low; read data taken at that same edge
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, input logic [3:0] be,
		output logic [31:0] rd);
		int k;
		k = 0;
		avs_address <= a;
		avs_writedata <= wd;
		avs_byteenable <= be;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 20);
		rd = avs_readdata;
		chk1(avs_waitrequest, 1'b0, "bus answer");
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask

	// counts cpu enable highs and peripheral enable lows over a window
	task automatic count_en(input int cyc, output int h, output int p);
		h = 0;
		p = 0;
		repeat (cyc) begin
			@(posedge clk);
			if (cpu_clk_en === 1'b1) h++;
			if (periph_clk_en !== 1'b1) p++;
		end
	endtask

	// waits a bounded time for the next resume pulse
	task automatic wait_resume(input int r);
		n = 0;
		while (res_cnt == r && n < 16) begin
			@(posedge clk);
			n++;
		end
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// whole run is about 2300 cycles; this limit leaves wide margin
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		$display("MISMATCH at %0t: run timed out", $time);
		summarize();
	end

	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		bus(1'b0, 4'h8, 32'h0, 4'hf, d);
		chk32(d, 32'h1, "status after reset");
		bus(1'b0, 4'h0, 32'h0, 4'hf, d);
		chk32(d, 32'h0, "divisor after reset"); // ratio 1:1
		chk1(cpu_clk_en, 1'b1, "cpu enable after reset");
		$display("test reset done");
		// next oscillator select writable only while unlocked
		bus(1'b1, 4'h4, 32'h300, 4'hf, d);
		bus(1'b0, 4'h4, 32'h0, 4'hf, d);
		chk32(d, 32'h3300, "osc select unlocked");
		locked <= 1'b1;
		bus(1'b1, 4'h4, 32'h500, 4'hf, d);
		bus(1'b0, 4'h4, 32'h0, 4'hf, d);
		chk32(d, 32'h3300, "osc select locked");
		$display("test oscillator done");
		foreach (rows[i]) begin
			watchdog_enable <= rows[i].wd;
			fm_enable <= rows[i].fm;
			repeat (3) @(posedge clk);
			c0 = clr_cnt;
			exec <= 1'b1;
			idle_sel <= rows[i].idle;
			@(posedge clk);
			exec <= 1'b0;
			repeat (5) @(posedge clk);
			#1;
			chk1(cpu_clk_en, 1'b0, "cpu halted");
			chk1(periph_clk_en, rows[i].periph, "periph clock");
			chk1(sysclk_src_en, rows[i].periph, "system clock");
			chk1(onchip_osc_en, rows[i].periph, "on-chip osc");
			chk1(rc_en, rows[i].rc, "rc clock");
			chk1(fm_active, rows[i].fma, "monitor");
			chk32(32'(clr_cnt - c0), 32'(rows[i].clr), "clear pulses");
			@(posedge clk);
			r0 = res_cnt;
			if (rows[i].by_wdt) wdt_timeout_async <= 1'b1;
			else irq_pending <= 1'b1;
			wait_resume(r0);
			irq_pending <= 1'b0;
			wdt_timeout_async <= 1'b0;
			#1;
			chk32(32'(res_cnt - r0), 32'h1, "one resume");
			chk1(cpu_clk_en, 1'b1, "cpu restored");
			chk1(resume_to_isr, rows[i].isr, "resume target");
			chk32({29'h0, current_oscillator}, 32'h3, "source kept");
			repeat (4) @(posedge clk);
			$display("test row %0d done", i);
		end
		// interrupt in the instruction cycle is held, then wakes
		r0 = res_cnt;
		exec <= 1'b1;
		idle_sel <= 1'b1;
		irq_pending <= 1'b1;
		@(posedge clk);
		exec <= 1'b0;
		// interrupt still pending through the entry cycle, so it must be parked
		@(posedge clk);
		irq_pending <= 1'b0;
		wait_resume(r0);
		#1;
		chk32(32'(res_cnt - r0), 32'h1, "held irq wakes");
		chk1(resume_to_isr, 1'b1, "held irq to isr");
		@(posedge clk);
		$display("test coincident done");
		for (int r = 0; r < 8; r++) begin
			bus(1'b1, 4'h0, {17'h0, 3'(r), 1'b1, 11'h0}, 4'hf, d);
			bus(1'b0, 4'h0, 32'h0, 4'hf, d);
			chk32(d, {17'h0, 3'(r), 1'b1, 11'h0}, "divisor readback");
			count_en(256, hi, plo);
			chk32(32'(hi), 32'(256 >> r), "doze cpu rate");
			chk32(32'(plo), 32'h0, "periph full speed");
			chk1(doze_active, 1'b1, "doze on");
		end
		bus(1'b1, 4'h0, 32'h0, 4'hf, d);
		count_en(16, hi, plo);
		chk32(32'(hi), 32'd16, "doze off full rate");
		$display("test doze done");
		// interrupt without recovery leaves doze alone, with recovery ends it
		bus(1'b1, 4'h0, 32'h2800, 4'hf, d);
		irq_pending <= 1'b1;
		@(posedge clk);
		irq_pending <= 1'b0;
		repeat (4) @(posedge clk);
		chk1(doze_active, 1'b1, "no recovery");
		bus(1'b1, 4'h0, 32'ha800, 4'hf, d);
		irq_pending <= 1'b1;
		@(posedge clk);
		irq_pending <= 1'b0;
		repeat (4) @(posedge clk);
		chk1(doze_active, 1'b0, "recovered");
		bus(1'b0, 4'h0, 32'h0, 4'hf, d);
		chk32(d, 32'ha000, "slowdown cleared");
		bus(1'b1, 4'h0, 32'h800, 4'h1, d);
		bus(1'b0, 4'h0, 32'h0, 4'hf, d);
		chk32(d, 32'ha000, "lane 1 off ignored");
		bus(1'b1, 4'hc, 32'hffff, 4'hf, d);
		bus(1'b0, 4'hc, 32'h0, 4'hf, d);
		chk32(d, 32'h0, "unmapped reads zero");
		$display("test recovery done");
		// a reset in sleep wakes and restores defaults
		watchdog_enable <= 1'b0;
		fm_enable <= 1'b0;
		exec <= 1'b1;
		idle_sel <= 1'b0;
		@(posedge clk);
		exec <= 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		chk1(cpu_clk_en, 1'b1, "reset wakes");
		@(posedge clk);
		bus(1'b0, 4'h8, 32'h0, 4'hf, d);
		chk32(d, 32'h1, "run after reset");
		$display("test second reset done");
		summarize();
	end
endmodule
